/* inc/conv_pkg.sv */
// constants and types for the conversion controller
// assumes a single 40 MHz system clock feeds every block
package conv_pkg;
	// converter resolution
	localparam int RESULT_W        = 12;
	// system clock
	localparam int CLK_HZ          = 40_000_000;
	localparam int CLK_PERIOD_NS   = 25;
	// ceiling on the converter step rate, rounded up to whole cycles
	localparam int CONV_CLK_MAX_HZ = 14_000_000;
	localparam int STEP_CYCLES     = (CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
	// power-up or wake settling wait, rounded up to whole cycles
	localparam int SETTLE_TIME_NS  = 10_000;
	localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// highest sustained sample rate and the shortest period it implies
	localparam int MAX_RATE_SPS    = 700_000;
	localparam int MIN_PERIOD_CYCLES = CLK_HZ / MAX_RATE_SPS;
	// acquisition length in converter steps
	localparam int SAMPLE_STEPS    = 2;
	// result buffer depth
	localparam int BUF_DEPTH       = 2;
	// controller states
	typedef enum logic [2:0] {
		st_off,
		st_settle,
		st_idle,
		st_sample,
		st_convert,
		st_store
	} conv_state_t;
endpackage

/* inc/result_stream_if.sv */
// result word stream between the controller and its buffer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface result_stream_if #(
	parameter int W = 12
) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* hdl/sar_stepper.sv */
// binary search register driving the internal dac code
// assumes load and step are single-cycle pulses from the controller
`timescale 1ns/100ps
module sar_stepper #(
	parameter int W = conv_pkg::RESULT_W
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// sequencing
	input  wire logic         load,
	input  wire logic         step,
	input  wire logic         cmp_high,
	// search state
	output logic [W-1:0]      trial,
	output logic              done
);
	localparam logic [W-1:0] MSB_ONE = {1'b1, {(W-1){1'b0}}};

	logic [W-1:0] mask;
	logic [W-1:0] next_trial;

	// keep the tested bit if input is above the dac, then try the next lower bit
	assign next_trial = (cmp_high ? trial : (trial & ~mask)) | (mask >> 1);
	assign done       = step & mask[0]; // last decision taken

	// msb first, lsb last
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			trial <= '0;
			mask  <= '0;
		end else if (load) begin
			trial <= MSB_ONE;
			mask  <= MSB_ONE;
		end else if (step && (mask != '0)) begin
			trial <= next_trial;
			mask  <= mask >> 1;
		end
	end

	// load puts the msb on trial first
	msb_first_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		load |=> (trial == MSB_ONE) && (mask == MSB_ONE))
		else $error("search did not start at the msb");
	// each step retires exactly one mask bit
	mask_walk_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(step && !load && mask != '0) |=> (mask == $past(mask) >> 1))
		else $error("search did not move one bit down");
endmodule

/* hdl/result_buffer.sv */
// small fifo holding finished results until the reader takes them
// assumes the reader pops with out_valid and out_ready in the same cycle
`timescale 1ns/100ps
module result_buffer #(
	parameter int W     = conv_pkg::RESULT_W,
	parameter int DEPTH = conv_pkg::BUF_DEPTH
) (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst_b,
	// fill side
	result_stream_if.snk                  wr,
	// drain side
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [W-1:0]                  out_data,
	output logic [$clog2(DEPTH+1)-1:0]    level
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic          push;
	logic          pop;

	// handshakes
	assign wr.ready  = (level != FULL);
	assign out_valid = (level != '0);
	assign push      = wr.valid & wr.ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr];

	// storage
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wr_ptr] <= wr.data;
	end

	// pointers and fill level
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
			level <= level + CW'(push) - CW'(pop);
		end
	end

	// last word read releases the valid level
	eoc_release_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(pop && !push && level == 1) |=> !out_valid)
		else $error("valid stayed after the last word was read");
endmodule

/* hdl/sar_conv_ctrl.sv */
// control for a successive approximation converter: start, sample, search, store
// assumes the comparator output is synchronous to clk_sys and the reader pops
// results with eoc and rd_ready
// a full buffer holds the search in its store state, so a slow reader loses no word;
// power_en low aborts the running conversion but keeps finished words in the buffer;
// starts are only looked at in idle, so a strobe that lands mid-conversion is lost
`timescale 1ns/100ps
module sar_conv_ctrl #(
	parameter int W            = conv_pkg::RESULT_W,
	parameter int SETTLE       = conv_pkg::SETTLE_CYCLES,
	parameter int STEP         = conv_pkg::STEP_CYCLES,
	parameter int SAMPLE_STEPS = conv_pkg::SAMPLE_STEPS,
	parameter int DEPTH        = conv_pkg::BUF_DEPTH
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// control
	input  wire logic         power_en,
	input  wire logic         start_req,
	input  wire logic         frame_start,
	input  wire logic         single_mode,
	// analog front end
	input  wire logic         cmp_high,
	output logic [W-1:0]      dac_code,
	output logic              track,
	// status
	output logic              warm,
	output logic              busy,
	output logic              done_status,
	output logic              eoc,
	// result read port
	input  wire logic         rd_ready,
	output logic [W-1:0]      rd_data
);
	localparam int SW = $clog2(SETTLE);
	localparam int DW = $clog2(STEP);
	localparam int AW = (SAMPLE_STEPS > 1) ? $clog2(SAMPLE_STEPS) : 1;
	localparam int LW = $clog2(DEPTH + 1);
	localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE - 1);
	localparam logic [DW-1:0] STEP_LAST   = DW'(STEP - 1);
	localparam logic [AW-1:0] SAMPLE_LAST = AW'(SAMPLE_STEPS - 1);
	localparam logic [LW-1:0] LEVEL_ONE   = LW'(1);

	conv_pkg::conv_state_t state;
	conv_pkg::conv_state_t next_state;

	logic [SW-1:0] settle_cnt;
	logic [DW-1:0] div_cnt;
	logic [AW-1:0] samp_cnt;
	logic [LW-1:0] level;
	logic          start_hit;
	logic          stepping;
	logic          step_tick;
	logic          load;
	logic          conv_step;
	logic          conv_done;
	logic          settle_end;
	logic          sample_end;
	logic          push;
	logic          pop;

	result_stream_if #(.W(W)) res ();

	// decoded conditions
	assign start_hit  = start_req | frame_start;
	assign stepping   = (state == conv_pkg::st_sample) | (state == conv_pkg::st_convert);
	assign step_tick  = stepping & (div_cnt == STEP_LAST);
	assign settle_end = (state == conv_pkg::st_settle) & (settle_cnt == SETTLE_LAST);
	assign sample_end = (state == conv_pkg::st_sample) & step_tick & (samp_cnt == SAMPLE_LAST);
	assign load       = sample_end;
	assign conv_step  = (state == conv_pkg::st_convert) & step_tick;
	assign push       = res.valid & res.ready;
	assign pop        = eoc & rd_ready;

	// outward status
	assign track = (state == conv_pkg::st_sample);
	assign warm  = (state != conv_pkg::st_off) & (state != conv_pkg::st_settle);
	assign busy  = stepping | (state == conv_pkg::st_store);

	// stored result offered to the buffer
	assign res.valid = (state == conv_pkg::st_store);
	assign res.data  = dac_code;

	// next state
	always_comb begin
		next_state = state;
		case (state)
			conv_pkg::st_off: begin
				if (power_en)
					next_state = conv_pkg::st_settle;
			end
			conv_pkg::st_settle: begin
				if (settle_end)
					next_state = conv_pkg::st_idle;
			end
			conv_pkg::st_idle: begin
				if (start_hit)
					next_state = conv_pkg::st_sample;
			end
			conv_pkg::st_sample: begin
				if (sample_end)
					next_state = conv_pkg::st_convert;
			end
			conv_pkg::st_convert: begin
				if (conv_done)
					next_state = conv_pkg::st_store;
			end
			conv_pkg::st_store: begin
				if (res.ready)
					next_state = single_mode ? conv_pkg::st_idle : conv_pkg::st_sample;
			end
			default: next_state = conv_pkg::st_off;
		endcase
		if (!power_en)
			next_state = conv_pkg::st_off;
	end

	// state register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			state <= conv_pkg::st_off;
		else
			state <= next_state;
	end

	// settling wait counter
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			settle_cnt <= '0;
		else if (state == conv_pkg::st_settle)
			settle_cnt <= settle_cnt + 1'b1;
		else
			settle_cnt <= '0;
	end

	// converter step divider
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			div_cnt <= '0;
		else if (stepping && !step_tick)
			div_cnt <= div_cnt + 1'b1;
		else
			div_cnt <= '0;
	end

	// acquisition step counter
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			samp_cnt <= '0;
		else if (state != conv_pkg::st_sample || sample_end)
			samp_cnt <= '0;
		else if (step_tick)
			samp_cnt <= samp_cnt + 1'b1;
	end

	// done status: a new result wins over a read that empties the buffer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			done_status <= 1'b0;
		else if (push)
			done_status <= 1'b1;
		else if (pop && level == LEVEL_ONE)
			done_status <= 1'b0;
	end

	// bit decisions
	sar_stepper #(
		.W        (W)
	) u_stepper (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.load     (load),
		.step     (conv_step),
		.cmp_high (cmp_high),
		.trial    (dac_code),
		.done     (conv_done)
	);

	// two-entry result buffer; eoc is its valid, the reader's read is its ready
	result_buffer #(
		.W         (W),
		.DEPTH     (DEPTH)
	) u_buffer (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.wr        (res),
		.out_valid (eoc),
		.out_ready (rd_ready),
		.out_data  (rd_data),
		.level     (level)
	);

	// no conversion before the settling wait ends
	settle_guard_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == conv_pkg::st_settle && settle_cnt != SETTLE_LAST)
			|=> (state == conv_pkg::st_settle || state == conv_pkg::st_off))
		else $error("left settling before the wait ended");
	// settling lasts several cycles at least
	settle_length_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		($rose(state == conv_pkg::st_settle) && power_en)
			|-> (state == conv_pkg::st_settle || !power_en) [*8])
		else $error("settling ended too soon");
	// step ticks are spaced by the divider
	step_rate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		step_tick |=> !step_tick [*2])
		else $error("converter step rate too high");
	// a full conversion takes its twelve steps then stores
	conv_length_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		load |-> ##[1:40] (conv_done || !power_en))
		else $error("conversion did not finish in time");
	// a stored result raises status and eoc
	done_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		push |=> (done_status && eoc))
		else $error("completion did not raise status and eoc");
	// eoc holds until a read
	eoc_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(eoc && !rd_ready) |=> eoc)
		else $error("eoc dropped without a read");
	// starts during a conversion are ignored
	busy_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == conv_pkg::st_convert && start_hit && !conv_done && power_en)
			|=> (state == conv_pkg::st_convert))
		else $error("start disturbed a running conversion");
	// single mode returns to idle after storing
	one_shot_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(push && single_mode && power_en) |=> (state == conv_pkg::st_idle))
		else $error("single mode did not stop after one result");
	// continuous mode restarts at once
	continuous_run_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(push && !single_mode && power_en) |=> (state == conv_pkg::st_sample))
		else $error("continuous mode did not restart");

	// a start seen in idle opens the acquisition window
	start_take_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == conv_pkg::st_idle && start_hit && power_en) |=> track)
		else $error("start did not open sampling");
	// idle waits for a start in either mode
	idle_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == conv_pkg::st_idle && !start_hit && power_en) |=> (state == conv_pkg::st_idle))
		else $error("conversion began without a start");
	// starts during acquisition do not cut it short
	sample_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(track && start_hit && !sample_end && power_en) |=> track)
		else $error("start disturbed the acquisition");
	// the search is loaded at the end of acquisition
	track_end_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		load |-> track ##1 !track)
		else $error("search loaded outside the acquisition end");
	// the trial code moves only on a decision
	dac_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state == conv_pkg::st_convert && !conv_step) |=> $stable(dac_code))
		else $error("trial code moved between decisions");
	// a full buffer holds the finished word in store
	store_stall_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(res.valid && !res.ready && power_en) |=> res.valid)
		else $error("stalled result was dropped");
	// a word pushed into an empty buffer is shown at once
	result_word_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(push && level == '0) |=> (rd_data == $past(dac_code)))
		else $error("stored result not offered to the reader");
	// the offered word holds until it is read
	rd_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(eoc && !rd_ready) |=> $stable(rd_data))
		else $error("offered result changed before a read");
	// reading the last word clears the status bit
	done_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(pop && !push && level == LEVEL_ONE) |=> !done_status)
		else $error("status stayed after the last read");
	// power_en low forces the converter off
	power_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!power_en |=> (!warm && !busy))
		else $error("converter stayed on without power");
	// warm only rises at the end of the settling wait
	warm_source_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(warm) |-> $past(settle_end))
		else $error("warm rose outside the settling end");

	// main scenarios
	one_shot_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
		push && single_mode ##[1:100] pop);
	back_to_back_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
		push && !single_mode ##[1:60] push);
	buffer_full_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
		res.valid && !res.ready);
	strobe_start_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
		state == conv_pkg::st_idle && frame_start && !start_req);
	stall_clear_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
		res.valid && !res.ready ##1 push);
endmodule

/* tb/result_reader.sv */
// reader model: the cpu or dma side popping finished results on eoc
// assumes go and slow come from the bench off the clock edge
`timescale 1ns/100ps
module result_reader (
	// clock and reset
	input  wire logic                         clk_sys,
	input  wire logic                         rst_b,
	// bench control
	input  wire logic                         go,
	input  wire logic                         slow,
	// result port
	input  wire logic                         eoc,
	input  wire logic [conv_pkg::RESULT_W-1:0] rd_data,
	output logic                              rd_ready
);
	logic [1:0]                  phase = 2'h0;
	logic [conv_pkg::RESULT_W-1:0] words[$];
	int                          n_pop = 0;
	int                          cyc = 0;
	int                          last_at = 0;
	int                          gap = 0;
	// read strobe, thinned to one cycle in four when slow
	assign rd_ready = go && (!slow || phase == 2'h0);
	// every pop is logged with the gap since the one before
	always @(posedge clk_sys) begin
		phase <= phase + 2'h1;
		cyc = cyc + 1;
		if (rst_b && eoc && rd_ready) begin
			words.push_back(rd_data);
			gap = cyc - last_at;
			last_at = cyc;
			n_pop = n_pop + 1;
		end
	end
endmodule

/* tb/tb_sar_conv_ctrl.sv */
// testbench for the conversion controller with a reader model on the result port
// assumes a shortened settle count; comparator is modelled from an input code
`timescale 1ns/100ps
module tb_sar_conv_ctrl;
	localparam int SETTLE = 16;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        power_en = 1'b0;
	logic        start_req = 1'b0;
	logic        frame_start = 1'b0;
	logic        single_mode = 1'b1;
	logic        cmp_high;
	logic [11:0] dac_code;
	logic        track;
	logic        warm;
	logic        busy;
	logic        done_status;
	logic        eoc;
	logic        rd_ready;
	logic [11:0] rd_data;
	logic        go = 1'b0;
	logic        slow = 1'b0;
	logic [11:0] ain = 12'h000;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          tick = 0;
	int          n;
	// input sits half a code above ain, so the search lands exactly on ain
	assign cmp_high = {ain, 1'b1} > {dac_code, 1'b0};
	sar_conv_ctrl #(.SETTLE(SETTLE)) dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .power_en(power_en), .start_req(start_req),
		.frame_start(frame_start), .single_mode(single_mode), .cmp_high(cmp_high),
		.dac_code(dac_code), .track(track), .warm(warm), .busy(busy),
		.done_status(done_status), .eoc(eoc), .rd_ready(rd_ready), .rd_data(rd_data)
	);
	result_reader rdr (
		.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .slow(slow),
		.eoc(eoc), .rd_data(rd_data), .rd_ready(rd_ready)
	);
	// 40 MHz clock
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// hang guard
	always @(posedge clk_sys) begin
		tick = tick + 1;
		if (tick == 20000) begin
			error_cnt = error_cnt + 1;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// power up with a start during settling; count to warm
	task automatic t_power();
		@(negedge clk_sys);
		power_en = 1'b1;
		n = 0;
		while (warm !== 1'b1 && n < 1000) begin
			@(negedge clk_sys);
			n = n + 1;
			start_req = (n == 4);
		end
		check("settle_len", n, SETTLE + 1);
		repeat (5) @(negedge clk_sys);
		check("busy_after_settle", busy, 1'b0);
	endtask
	// one conversion per start, timing, result, hold and release
	task automatic t_single(input logic [11:0] v, input logic use_frame);
		ain = v;
		single_mode = 1'b1;
		@(negedge clk_sys);
		start_req = !use_frame;
		frame_start = use_frame;
		@(negedge clk_sys);
		start_req = 1'b0;
		frame_start = 1'b0;
		check("track_on", track, 1'b1);
		n = 1;
		while (eoc !== 1'b1 && n < 200) begin
			start_req = (n == 20);
			@(negedge clk_sys);
			n = n + 1;
		end
		start_req = 1'b0;
		check("conv_len", n, 44);
		check("result", rd_data, v);
		check("done_bit", done_status, 1'b1);
		repeat (60) @(negedge clk_sys);
		check("eoc_held", eoc, 1'b1);
		check("one_shot_idle", busy, 1'b0);
		n = rdr.n_pop;
		go = 1'b1;
		@(negedge clk_sys);
		@(negedge clk_sys);
		go = 1'b0;
		check("pops", rdr.n_pop - n, 1);
		check("eoc_released", eoc, 1'b0);
		check("done_cleared", done_status, 1'b0);
	endtask
	// continuous running: stall with full buffer, then dma drains it
	task automatic t_cont();
		ain = 12'h3c5;
		single_mode = 1'b0;
		rdr.words.delete();
		@(negedge clk_sys);
		start_req = 1'b1;
		@(negedge clk_sys);
		start_req = 1'b0;
		repeat (200) @(negedge clk_sys);
		check("stall_busy", busy, 1'b1);
		check("stall_eoc", eoc, 1'b1);
		go = 1'b1;
		slow = 1'b1;
		n = rdr.n_pop;
		repeat (2000) begin
			if (rdr.n_pop - n < 8)
				@(negedge clk_sys);
		end
		check("slow_pops", rdr.n_pop - n >= 8, 1'b1);
		slow = 1'b0;
		n = rdr.n_pop;
		repeat (200) @(negedge clk_sys);
		check("steady_gap", rdr.gap, 43);
		single_mode = 1'b1;
		repeat (100) @(negedge clk_sys);
		go = 1'b0;
		check("stopped", busy, 1'b0);
		check("drained", eoc, 1'b0);
		foreach (rdr.words[i])
			check("cont_word", rdr.words[i], 12'h3c5);
		check("cont_count", rdr.words.size() >= 10, 1'b1);
	endtask
	// power drop mid-conversion aborts; wake needs the settle wait again
	task automatic t_sleep();
		ain = 12'ha5a;
		@(negedge clk_sys);
		start_req = 1'b1;
		@(negedge clk_sys);
		start_req = 1'b0;
		repeat (10) @(negedge clk_sys);
		power_en = 1'b0;
		@(negedge clk_sys);
		check("off_warm", warm, 1'b0);
		check("off_busy", busy, 1'b0);
		check("off_eoc", eoc, 1'b0);
		t_power();
		t_single(12'ha5a, 1'b1);
	endtask
	// main sequence
	initial begin
		repeat (20) @(negedge clk_sys);
		rst_b = 1'b1;
		check("rst_warm", warm, 1'b0);
		check("rst_eoc", eoc, 1'b0);
		t_power();
		t_single(12'h000, 1'b0);
		t_single(12'hfff, 1'b1);
		t_single(12'h800, 1'b0);
		t_single(12'h5a3, 1'b1);
		t_cont();
		t_sleep();
		print_verdict();
	end
endmodule
